// ---- brci_pkg.sv ----
// Shared constants and types for the barometer command and readout logic.
package brci_pkg;

    // Bus identity and register map.
    localparam logic [6:0] DEV_ADDR = 7'h6D;
    localparam logic [7:0] REG_RESULT = 8'h06;
    localparam logic [7:0] REG_MEASURE = 8'h30;
    localparam logic [7:0] CMD_MEASURE = 8'h0A;

    // Byte framing on the serial link.
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_FULL = 4'h8;
    localparam int PKT_W = 40;
    localparam int RX_W = 9;
    localparam int FIFO_DEPTH = 32;

    // Reset values of the stored results.
    localparam logic [23:0] PRES_RST = 24'h00_0000;
    localparam logic [15:0] TEMP_RST = 16'h0000;
    localparam logic [39:0] PKT_RST = 40'h00_0000_0000;

    // Conversion timing: the whole cycle, temperature then pressure.
    localparam int CLK_HZ = 10_000_000;
    localparam int CONV_TIME_US = 5000;
    localparam int CONV_CYCLES_DEF = CONV_TIME_US * (CLK_HZ / 1_000_000);

    typedef enum logic [2:0] {
        LK_IDLE = 3'h0,
        LK_ADDR = 3'h1,
        LK_ADDR_ACK = 3'h3,
        LK_RX = 3'h2,
        LK_RX_ACK = 3'h6,
        LK_TX = 3'h7,
        LK_TX_ACK = 3'h5
    } brci_link_t;

    typedef enum logic [1:0] {
        MS_SLEEP = 2'h0,
        MS_TEMP = 2'h1,
        MS_PRES = 2'h3,
        MS_COMP = 2'h2
    } brci_meas_t;

endpackage

// ---- brci_strm_if.sv ----
// Valid and ready stream carrier between the block's own modules.
interface brci_strm_if #(
    parameter int W = 9
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

// ---- brci_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides.
module brci_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    brci_strm_if.snk wr,
    brci_strm_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
    localparam logic [AW:0] CNT_ONE = (AW + 1)'(1);
    localparam logic [AW-1:0] PTR_ONE = AW'(1);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign wr.ready = (cnt_q != CNT_FULL);
    assign rd.valid = (cnt_q != '0);
    assign rd.data = mem_q[rp_q];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wp_q] <= wr.data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= wp_q + PTR_ONE;
            end
            if (pop)
            begin
                rp_q <= rp_q + PTR_ONE;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + CNT_ONE;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - CNT_ONE;
            end
        end
    end
endmodule

// ---- brci_comp.sv ----
// Compensation stage: trims raw conversion words into final result values.
module brci_comp #(
    parameter logic [23:0] P_TRIM = 24'h00_0000,
    parameter logic [15:0] T_TRIM = 16'h0000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [23:0] raw_p,
    input wire logic [15:0] raw_t,
    output logic valid,
    output logic [23:0] comp_p,
    output logic [15:0] comp_t
);
    // The trim is a plain offset; wrap-around is the caller's concern.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            valid <= 1'b0;
            comp_p <= 24'h00_0000;
            comp_t <= 16'h0000;
        end
        else
        begin
            valid <= start;
            if (start)
            begin
                comp_p <= raw_p + P_TRIM;
                comp_t <= 16'($signed(raw_t) + $signed(T_TRIM));
            end
        end
    end
endmodule

// ---- brci_top.sv ----
// Two-wire slave command decoder, measurement sequencer and result readout.
module brci_top
    import brci_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    input wire logic [15:0] RAW_TEMP,
    input wire logic [23:0] RAW_PRES,
    output logic TEMP_CONV_EN,
    output logic PRES_CONV_EN,
    output logic AWAKE
);
    localparam int HALF_CYCLES = (CONV_CYCLES / 2 < 1) ? 1 : CONV_CYCLES / 2;
    localparam logic [31:0] PHASE_LAST = 32'(HALF_CYCLES - 1);
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    localparam logic [3:0] BIT_ONE = 4'h1;

    // Link edge detection.
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // Link state.
    brci_link_t lk_q;
    logic [3:0] bit_q;
    logic [7:0] rx_q;
    logic rw_q;
    logic oe_n_q;
    logic [PKT_W-1:0] tx_q;
    logic first_q;
    logic push_q;
    logic [RX_W-1:0] push_data_q;
    logic acc_q;
    logic addr_hit;
    logic [7:0] rx_byte;

    // Command decode and measurement.
    logic [7:0] ptr_q;
    logic req_q;
    brci_meas_t ms_q;
    logic [31:0] cnt_q;
    logic [15:0] raw_t_q;
    logic [23:0] raw_p_q;
    logic comp_go_q;
    logic comp_valid;
    logic [23:0] comp_p;
    logic [15:0] comp_t;
    logic [23:0] res_p_q;
    logic [15:0] res_t_q;
    logic temp_en_q;
    logic pres_en_q;
    logic awake_q;

    brci_strm_if #(.W(RX_W)) rx_in ();
    brci_strm_if #(.W(RX_W)) rx_out ();

    function automatic logic is_measure(input logic [7:0] ptr, input logic [7:0] cmd);
        is_measure = (ptr == REG_MEASURE) && (cmd == CMD_MEASURE);
    endfunction

    // Wire order of the result packet, first byte sent in the top bits.
    function automatic logic [PKT_W-1:0] pack(input logic [23:0] p, input logic [15:0] t);
        pack = {p[7:0], p[15:8], p[23:16], t[15:8], t[7:0]};
    endfunction

    assign scl_rise = SCL_IN && !scl_prev_q;
    assign scl_fall = !SCL_IN && scl_prev_q;
    assign start_seen = SCL_IN && scl_prev_q && sda_prev_q && !SDA_IN;
    assign stop_seen = SCL_IN && scl_prev_q && !sda_prev_q && SDA_IN;
    assign addr_hit = (rx_q[7:1] == DEV_ADDR);
    assign rx_byte = {rx_q[6:0], SDA_IN};

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_prev_q <= SCL_IN;
            sda_prev_q <= SDA_IN;
        end
    end

    // Bit-level link sequencer; SDA changes only after SCL has fallen.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            lk_q <= LK_IDLE;
            bit_q <= BIT_ZERO;
            rx_q <= 8'h00;
            rw_q <= 1'b0;
            oe_n_q <= 1'b1;
        end
        else if (start_seen)
        begin
            lk_q <= LK_ADDR;
            bit_q <= BIT_ZERO;
            oe_n_q <= 1'b1;
        end
        else if (stop_seen)
        begin
            lk_q <= LK_IDLE;
            oe_n_q <= 1'b1;
        end
        else
        begin
            case (lk_q)
                LK_ADDR:
                begin
                    if (scl_rise && bit_q != BIT_FULL)
                    begin
                        rx_q <= rx_byte;
                        bit_q <= bit_q + BIT_ONE;
                    end
                    else if (scl_fall && bit_q == BIT_FULL)
                    begin
                        bit_q <= BIT_ZERO;
                        if (addr_hit)
                        begin
                            lk_q <= LK_ADDR_ACK;
                            rw_q <= rx_q[0];
                            oe_n_q <= 1'b0;
                        end
                        else
                        begin
                            lk_q <= LK_IDLE;
                        end
                    end
                end
                LK_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_q <= BIT_ZERO;
                        if (rw_q)
                        begin
                            lk_q <= LK_TX;
                            oe_n_q <= tx_q[PKT_W-1];
                        end
                        else
                        begin
                            lk_q <= LK_RX;
                            oe_n_q <= 1'b1;
                        end
                    end
                end
                LK_RX:
                begin
                    if (scl_rise && bit_q != BIT_FULL)
                    begin
                        rx_q <= rx_byte;
                        bit_q <= bit_q + BIT_ONE;
                    end
                    else if (scl_fall && bit_q == BIT_FULL)
                    begin
                        // A byte that found the queue full is refused with NACK.
                        lk_q <= LK_RX_ACK;
                        oe_n_q <= !acc_q;
                        bit_q <= BIT_ZERO;
                    end
                end
                LK_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        lk_q <= LK_RX;
                        oe_n_q <= 1'b1;
                    end
                end
                LK_TX:
                begin
                    if (scl_rise && bit_q != BIT_FULL)
                    begin
                        bit_q <= bit_q + BIT_ONE;
                    end
                    else if (scl_fall && bit_q == BIT_FULL)
                    begin
                        lk_q <= LK_TX_ACK;
                        oe_n_q <= 1'b1;
                        bit_q <= BIT_ZERO;
                    end
                    else if (scl_fall)
                    begin
                        oe_n_q <= tx_q[PKT_W-1];
                    end
                end
                LK_TX_ACK:
                begin
                    if (scl_rise && SDA_IN)
                    begin
                        lk_q <= LK_IDLE;
                    end
                    else if (scl_fall)
                    begin
                        lk_q <= LK_TX;
                        oe_n_q <= tx_q[PKT_W-1];
                    end
                end
                default:
                begin
                    oe_n_q <= 1'b1;
                end
            endcase
        end
    end

    // The packet is frozen when the read address is taken, so a result that
    // lands mid-transfer never mixes with the bytes already on the wire.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            tx_q <= PKT_RST;
        end
        else if (lk_q == LK_ADDR && scl_fall && bit_q == BIT_FULL && addr_hit && rx_q[0])
        begin
            tx_q <= pack(res_p_q, res_t_q);
        end
        else if (lk_q == LK_TX && scl_rise && bit_q != BIT_FULL)
        begin
            tx_q <= {tx_q[PKT_W-2:0], 1'b0};
        end
    end

    // Received write bytes enter the queue tagged with a first-byte mark.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            first_q <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= '0;
            acc_q <= 1'b0;
        end
        else
        begin
            push_q <= 1'b0;
            if (lk_q == LK_ADDR && scl_fall && bit_q == BIT_FULL && addr_hit && !rx_q[0])
            begin
                first_q <= 1'b1;
            end
            if (lk_q == LK_RX && scl_rise && bit_q == BIT_LAST)
            begin
                push_q <= 1'b1;
                push_data_q <= {first_q, rx_byte};
            end
            if (push_q)
            begin
                acc_q <= rx_in.ready;
                if (rx_in.ready)
                begin
                    first_q <= 1'b0;
                end
            end
        end
    end

    assign rx_in.valid = push_q;
    assign rx_in.data = push_data_q;

    brci_fifo #(
        .W(RX_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst(RESET),
        .wr(rx_in.snk),
        .rd(rx_out.src)
    );

    // Commands drain only while asleep; during a conversion they wait queued.
    assign rx_out.ready = (ms_q == MS_SLEEP) && !req_q;

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ptr_q <= REG_RESULT;
            req_q <= 1'b0;
        end
        else if (ms_q != MS_SLEEP)
        begin
            req_q <= 1'b0;
        end
        else if (rx_out.valid && rx_out.ready)
        begin
            if (rx_out.data[RX_W-1])
            begin
                ptr_q <= rx_out.data[7:0];
            end
            else if (is_measure(ptr_q, rx_out.data[7:0]))
            begin
                req_q <= 1'b1;
            end
        end
    end

    // Measurement sequencer; nothing on the read path reaches it.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ms_q <= MS_SLEEP;
            cnt_q <= '0;
            raw_t_q <= TEMP_RST;
            raw_p_q <= PRES_RST;
            comp_go_q <= 1'b0;
            temp_en_q <= 1'b0;
            pres_en_q <= 1'b0;
            awake_q <= 1'b0;
        end
        else
        begin
            comp_go_q <= 1'b0;
            case (ms_q)
                MS_SLEEP:
                begin
                    cnt_q <= '0;
                    if (req_q)
                    begin
                        ms_q <= MS_TEMP;
                        temp_en_q <= 1'b1;
                        awake_q <= 1'b1;
                    end
                end
                MS_TEMP:
                begin
                    if (cnt_q == PHASE_LAST)
                    begin
                        raw_t_q <= RAW_TEMP;
                        cnt_q <= '0;
                        ms_q <= MS_PRES;
                        temp_en_q <= 1'b0;
                        pres_en_q <= 1'b1;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + CNT_ONE;
                    end
                end
                MS_PRES:
                begin
                    if (cnt_q == PHASE_LAST)
                    begin
                        raw_p_q <= RAW_PRES;
                        cnt_q <= '0;
                        ms_q <= MS_COMP;
                        pres_en_q <= 1'b0;
                        comp_go_q <= 1'b1;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + CNT_ONE;
                    end
                end
                MS_COMP:
                begin
                    if (comp_valid)
                    begin
                        ms_q <= MS_SLEEP;
                        awake_q <= 1'b0;
                    end
                end
                default:
                begin
                    ms_q <= MS_SLEEP;
                    temp_en_q <= 1'b0;
                    pres_en_q <= 1'b0;
                    awake_q <= 1'b0;
                end
            endcase
        end
    end

    brci_comp u_comp (
        .clk(CLK),
        .rst(RESET),
        .start(comp_go_q),
        .raw_p(raw_p_q),
        .raw_t(raw_t_q),
        .valid(comp_valid),
        .comp_p(comp_p),
        .comp_t(comp_t)
    );

    // Results change in one step, only once compensation is done.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            res_p_q <= PRES_RST;
            res_t_q <= TEMP_RST;
        end
        else if (comp_valid)
        begin
            res_p_q <= comp_p;
            res_t_q <= comp_t;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            SDA_OUT <= 1'b0;
            SDA_OE_N <= 1'b1;
            TEMP_CONV_EN <= 1'b0;
            PRES_CONV_EN <= 1'b0;
            AWAKE <= 1'b0;
        end
        else
        begin
            SDA_OUT <= 1'b0;
            SDA_OE_N <= oe_n_q;
            TEMP_CONV_EN <= temp_en_q;
            PRES_CONV_EN <= pres_en_q;
            AWAKE <= awake_q;
        end
    end
endmodule

// ---- brci_host.sv ----
// Host two-wire master model that drives the bus clock and pulls data low.
module brci_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic pull
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 10;
    initial
    begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic step(input logic s, input logic p);
        scl = s;
        pull = p;
        repeat (HALF) @(negedge clk);
    endtask
    // Data moves only while the clock is low, so no false start or stop appears.
    task automatic put(input logic p);
        step(1'b0, pull);
        step(1'b0, p);
        step(1'b1, p);
    endtask
    task automatic start();
        step(1'b1, 1'b1);
    endtask
    task automatic rstart();
        step(1'b0, pull);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, pull);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic wr(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            put(~b[i]);
        put(1'b0);
        ack = ~sda;
    endtask
    // The last byte wanted is refused, which ends the read.
    task automatic rd(input logic more, output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            put(1'b0);
            b[i] = sda;
        end
        put(more);
    endtask
endmodule

// ---- brci_top_chk.sv ----
// Concurrent checks on the ports of the barometer command and readout block.
module brci_top_chk #(
    parameter int CONV_CYCLES = 40
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N,
    input wire logic [15:0] RAW_TEMP,
    input wire logic [23:0] RAW_PRES,
    input wire logic TEMP_CONV_EN,
    input wire logic PRES_CONV_EN,
    input wire logic AWAKE
);
    localparam int HALF = CONV_CYCLES / 2;
    int pres_cnt_q;
    int awake_cnt_q;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    always_ff @(posedge CLK)
    begin
        pres_cnt_q <= (RESET || !PRES_CONV_EN) ? 0 : pres_cnt_q + 1;
    end
    always_ff @(posedge CLK)
    begin
        awake_cnt_q <= (RESET || !AWAKE) ? 0 : awake_cnt_q + 1;
    end
    sequence temp_done;
        TEMP_CONV_EN ##1 !TEMP_CONV_EN;
    endsequence
    sequence pres_phase;
        PRES_CONV_EN && !TEMP_CONV_EN;
    endsequence
    chk_data_low: assert property (SDA_OUT == 1'b0)
        else $error("data output not held low");
    // A drive change while the bus clock is high would look like a start or stop.
    chk_drive_clk_low: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
        else $error("data drive changed while bus clock high");
    chk_conv_excl: assert property (!(TEMP_CONV_EN && PRES_CONV_EN))
        else $error("both conversions enabled");
    chk_temp_before: assert property ($rose(PRES_CONV_EN) |->
        $past(TEMP_CONV_EN, 1) || $past(TEMP_CONV_EN, 2))
        else $error("pressure phase without temperature phase");
    chk_temp_to_pres: assert property (temp_done |-> ##[0:2] pres_phase)
        else $error("pressure phase missing after temperature");
    chk_wake_temp: assert property ($rose(AWAKE) |-> ##[0:1] TEMP_CONV_EN)
        else $error("wake without temperature phase");
    chk_conv_awake: assert property ((TEMP_CONV_EN || PRES_CONV_EN) |-> AWAKE)
        else $error("conversion while asleep");
    chk_pres_len: assert property ($fell(PRES_CONV_EN) |->
        pres_cnt_q inside {[HALF - 1:HALF + 1]})
        else $error("pressure phase length wrong");
    chk_back_sleep: assert property ($fell(PRES_CONV_EN) |-> ##[1:4] !AWAKE)
        else $error("no return to sleep after pressure phase");
    chk_awake_bound: assert property (awake_cnt_q <= CONV_CYCLES + 8)
        else $error("awake longer than one cycle");
endmodule
bind brci_top brci_top_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .CLK(CLK), .RESET(RESET), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .RAW_TEMP(RAW_TEMP),
    .RAW_PRES(RAW_PRES), .TEMP_CONV_EN(TEMP_CONV_EN),
    .PRES_CONV_EN(PRES_CONV_EN), .AWAKE(AWAKE)
);

// ---- test_barometer_i2c_command_readout.sv ----
// Self-checking bench: a host model drives the bus, a byte model predicts reads.
module test_barometer_i2c_command_readout
    import brci_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 6000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, pull, sda_oe_n, sda_out, t_en, p_en, awake;
    logic [15:0] raw_t = 16'h0000;
    logic [23:0] raw_p = 24'h00_0000;
    logic [15:0] exp_t = 16'h0000;
    logic [23:0] exp_p = 24'h00_0000;
    int n_mismatch = 0;
    int checks_done = 0;
    int q_exp[$];
    // The bus has a pull-up, so a released line reads high.
    wire logic sda = ~(pull | (sda_oe_n === 1'b0));
    always #50 clk = ~clk;
    brci_host host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
    brci_top #(.CONV_CYCLES(CONV)) dut (
        .CLK(clk), .RESET(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE_N(sda_oe_n), .RAW_TEMP(raw_t), .RAW_PRES(raw_p),
        .TEMP_CONV_EN(t_en), .PRES_CONV_EN(p_en), .AWAKE(awake)
    );
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        chk8(what, {7'h00, e}, {7'h00, g});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic model();
        q_exp = {exp_p[7:0], exp_p[15:8], exp_p[23:16], exp_t[15:8], exp_t[7:0], 8'h00, 8'h00};
    endtask
    task automatic wait_for(ref logic s, input logic v, input string what);
        int k;
        k = 0;
        while (s !== v && k < 20000)
        begin
            @(negedge clk);
            k++;
        end
        chk1(what, v, s);
    endtask
    task automatic measure();
        logic ack;
        host.start();
        host.wr({DEV_ADDR, 1'b0}, ack);
        chk1("request address ack", 1'b1, ack);
        host.wr(REG_MEASURE, ack);
        chk1("request pointer ack", 1'b1, ack);
        host.wr(CMD_MEASURE, ack);
        chk1("request command ack", 1'b1, ack);
        host.stop();
    endtask
    task automatic fetch(input int n, input logic aw);
        logic ack;
        logic [7:0] b;
        host.start();
        host.wr({DEV_ADDR, 1'b0}, ack);
        chk1("pointer address ack", 1'b1, ack);
        host.wr(REG_RESULT, ack);
        chk1("pointer ack", 1'b1, ack);
        host.rstart();
        host.wr({DEV_ADDR, 1'b1}, ack);
        chk1("read address ack", 1'b1, ack);
        for (int i = 0; i < n; i++)
        begin
            host.rd(i < n - 1, b);
            chk8("result byte", q_exp[i][7:0], b);
        end
        host.stop();
        chk1("awake after read", aw, awake);
        chk1("data output level", 1'b0, sda_out);
    endtask
    initial
    begin
        logic ack;
        logic [15:0] t_keep;
        void'($urandom(32'h2e1e_1ff5));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (60) @(negedge clk);
        chk1("asleep after reset", 1'b0, awake);
        model();
        fetch(5, 1'b0);
        host.start();
        host.wr({DEV_ADDR ^ 7'($urandom_range(127, 1)), 1'b1}, ack);
        chk1("foreign address ack", 1'b0, ack);
        host.stop();
        // A command byte other than the measurement code must not wake the block.
        host.start();
        host.wr({DEV_ADDR, 1'b0}, ack);
        host.wr(REG_MEASURE, ack);
        host.wr(CMD_MEASURE ^ 8'($urandom_range(255, 1)), ack);
        chk1("wrong command ack", 1'b1, ack);
        host.stop();
        repeat (20) @(negedge clk);
        chk1("asleep after wrong command", 1'b0, awake);
        for (int r = 0; r < 3; r++)
        begin
            raw_p = 24'($urandom);
            // The first round uses a negative temperature.
            raw_t = 16'($urandom) | (r == 0 ? 16'h8000 : 16'h0000);
            t_keep = raw_t;
            measure();
            fetch(5, 1'b1);
            chk1("temperature phase", 1'b1, t_en);
            wait_for(p_en, 1'b1, "pressure phase");
            raw_t = ~raw_t;
            wait_for(awake, 1'b0, "back asleep");
            chk1("pressure phase over", 1'b0, p_en);
            exp_p = raw_p;
            exp_t = t_keep;
            model();
            fetch(7, 1'b0);
            fetch(3, 1'b0);
            fetch(5, 1'b0);
        end
        summarize();
    end
    // About twice the expected run, so a stuck handshake cannot hang the run.
    initial
    begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule
